// ==== pkg/sqd_pkg.sv ====
package sqd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths of the stream window and the decoded code
    localparam int WIN_BITS  = 23;
    localparam int CODE_BITS = 9;
    localparam int SYN_BITS  = 11;
    localparam int CNT_BITS  = 5;
    localparam int RATE_BITS = 16;
    localparam int FIFO_DEPTH = 8;

    // Cyclic code generator; a rotation is a code word when it leaves no remainder
    localparam logic [SYN_BITS:0] GEN_POLY  = 12'hc75;
    // Fixed marker in the top three bits of a code word
    localparam logic [2:0]        CW_MARKER = 3'h4;
    localparam int                MARK_LSB  = 20;
    localparam int                CODE_LSB  = 11;

    // Turn-off pattern and primary code set; plain defaults, set per deployment
    localparam logic [WIN_BITS-1:0]      SQUELCH_TURNOFF_PATTERN = 23'h2aaaaa;
    localparam logic [(1<<CODE_BITS)-1:0] PRIMARY_MASK           = {512{1'b1}};

    ////////////////////////////////////////////////////////////////////////////
    // Timing: the gate is one second so the bit count equals bits per second
    localparam int CLK_HZ       = 40_000_000;
    localparam int GATE_TIME_MS = 1000;
    localparam int GATE_CYCLES_DEF = (CLK_HZ / 1000) * GATE_TIME_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        SQD_ENT_CODE,
        SQD_ENT_NPC,
        SQD_ENT_TOC
    } sqd_kind_e;

    typedef struct packed {
        sqd_kind_e              kind;
        logic [CODE_BITS-1:0]   code;   // Three octal digits
    } sqd_entry_s;

    typedef struct packed {
        logic                   valid;
        logic                   level;  // 1 = positive peak
    } sqd_bit_s;

    typedef struct packed {
        logic                   valid;
        logic [WIN_BITS-1:0]    bits;
    } sqd_raw_s;

    typedef enum logic [2:0] {
        SQD_IDLE,
        SQD_ARMED,
        SQD_GATE,
        SQD_ROTATE,
        SQD_EMIT
    } sqd_state_e;

    // Remainder of a 23-bit word divided by the generator
    function automatic logic [SYN_BITS-1:0] sqd_syndrome(input logic [WIN_BITS-1:0] w);
        logic [WIN_BITS-1:0] r;
        r = w;
        for (int i = WIN_BITS - 1; i >= SYN_BITS; i--) begin
            if (r[i]) begin
                r[i -: SYN_BITS + 1] = r[i -: SYN_BITS + 1] ^ GEN_POLY;
            end
        end
        return r[SYN_BITS-1:0];
    endfunction

    // True when w is any rotation of the turn-off pattern
    function automatic logic sqd_is_turnoff(input logic [WIN_BITS-1:0] w);
        logic [WIN_BITS-1:0] p;
        logic                hit;
        p   = SQUELCH_TURNOFF_PATTERN;
        hit = 1'b0;
        for (int i = 0; i < WIN_BITS; i++) begin
            hit = hit | (w == p);
            p   = {p[WIN_BITS-2:0], p[WIN_BITS-1]};
        end
        return hit;
    endfunction

endpackage

// ==== core/sqd_fifo.sv ====
module sqd_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             srst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        nonempty;
    } sqd_fifo_state_s;

    sqd_fifo_state_s s_q;
    sqd_fifo_state_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Shift-down storage keeps the head in slot zero, so the output is a flop
    always_comb begin
        logic          pop;
        logic          push;
        logic [CW-1:0] wr;
        s_d  = s_q;
        pop  = s_q.nonempty && out_ready_in;
        push = in_valid_in && !s_q.full;
        wr   = s_q.cnt - CW'(pop);
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_d.mem[i] = s_q.mem[i + 1];
            end
        end
        if (push) begin
            s_d.mem[wr] = in_data_in;
        end
        s_d.cnt      = wr + CW'(push);
        s_d.full     = (s_d.cnt == CW'(DEPTH));
        s_d.nonempty = (s_d.cnt != '0);
    end

    // Register the whole state
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_out  = !s_q.full;
    assign out_valid_out = s_q.nonempty;
    assign out_data_out  = s_q.mem[0];

endmodule

// ==== core/sqd_decoder.sv ====
// Contract
// - Show latest 23 received bits
// - Rotate held bits 23 times, test each
// - First entry is primary code or marker
// - Remaining candidates follow in ascending order
// - Full-period turn-off reports only turn-off entry
// - Turn-off-only period leaves raw window empty
// - Raw window shown even with no codes
// - Raw window is rotated register contents
// - Measure incoming bit rate in bits/second
// - Single-shot arm readies one measurement
// - Polarity input inverts bit mapping
// - Continuous mode re-arms after each measurement
module sqd_decoder #(
    parameter int GATE_CYCLES = sqd_pkg::GATE_CYCLES_DEF
) (
    input  wire logic                              ref_clk_in,
    input  wire logic                              srst_in,
    input  wire sqd_pkg::sqd_bit_s                 rx_bit_in,
    input  wire logic                              polarity_invert_in,
    input  wire logic                              arm_in,
    input  wire logic                              continuous_in,
    input  wire logic                              stop_in,
    output sqd_pkg::sqd_raw_s                      raw_out,
    output logic [sqd_pkg::RATE_BITS-1:0]          rate_bps_out,
    output sqd_pkg::sqd_entry_s                    entry_out,
    output logic                                   entry_valid_out,
    input  wire logic                              entry_ready_in,
    output logic                                   armed_out,
    output logic                                   busy_out,
    output logic                                   done_out
);
    import sqd_pkg::*;

    typedef struct packed {
        sqd_state_e                             st;
        logic [WIN_BITS-1:0]                    win;
        logic [CNT_BITS-1:0]                    fill;
        logic [31:0]                            gate_cnt;
        logic [RATE_BITS-1:0]                   bit_cnt;
        logic                                   toc_only;
        logic                                   any_full;
        logic [WIN_BITS-1:0]                    rot;
        logic [CNT_BITS-1:0]                    rot_cnt;
        logic [WIN_BITS-1:0][CODE_BITS-1:0]     list;
        logic [CNT_BITS-1:0]                    lcnt;
        logic                                   prim_ok;
        logic [CNT_BITS-1:0]                    prim_idx;
        logic [CNT_BITS-1:0]                    emit_idx;
        logic                                   head_done;
        sqd_raw_s                               raw;
        logic [RATE_BITS-1:0]                   rate;
        logic                                   armed;
        logic                                   busy;
        logic                                   done;
    } sqd_state_s;

    sqd_state_s s_q;
    sqd_state_s s_d;

    sqd_entry_s push_entry;
    logic       push_valid;
    logic       fifo_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic                 rx_bit;
        logic [WIN_BITS-1:0]  win_n;
        logic [CODE_BITS-1:0] code;
        logic                 cand;
        logic                 dup;
        int                   pos;
        logic                 p_ok;
        logic [CNT_BITS-1:0]  p_idx;
        s_d        = s_q;
        push_valid = 1'b0;
        push_entry = '{kind: SQD_ENT_NPC, code: '0};
        rx_bit     = rx_bit_in.level ^ polarity_invert_in;
        win_n      = {s_q.win[WIN_BITS-2:0], rx_bit};
        code       = s_q.rot[CODE_LSB +: CODE_BITS];
        cand       = (sqd_syndrome(s_q.rot) == '0)
                     && (s_q.rot[MARK_LSB +: 3] == CW_MARKER);
        dup        = 1'b0;
        pos        = 0;
        p_ok       = 1'b0;
        p_idx      = '0;
        s_d.done   = 1'b0;

        // The window follows the stream at all times; decoding works on a snapshot
        if (rx_bit_in.valid) begin
            s_d.win = win_n;
            if (s_q.fill != CNT_BITS'(WIN_BITS)) begin
                s_d.fill = s_q.fill + 1'b1;
            end
        end

        // Sorted insertion position and duplicate check for the candidate
        for (int i = 0; i < WIN_BITS; i++) begin
            if (i < int'(s_q.lcnt)) begin
                if (s_q.list[i] < code) begin
                    pos = pos + 1;
                end
                if (s_q.list[i] == code) begin
                    dup = 1'b1;
                end
            end
        end

        // Lowest listed code that belongs to the primary set
        for (int i = WIN_BITS - 1; i >= 0; i--) begin
            if (i < int'(s_q.lcnt) && PRIMARY_MASK[s_q.list[i]]) begin
                p_ok  = 1'b1;
                p_idx = CNT_BITS'(i);
            end
        end

        case (s_q.st)
            SQD_IDLE: begin
                if (arm_in || continuous_in) begin
                    s_d.st    = SQD_ARMED;
                    s_d.armed = 1'b1;
                end
            end
            SQD_ARMED: begin
                // The first bit after arming opens the sampling period
                if (rx_bit_in.valid) begin
                    s_d.st       = SQD_GATE;
                    s_d.armed    = 1'b0;
                    s_d.busy     = 1'b1;
                    s_d.gate_cnt = '0;
                    s_d.bit_cnt  = RATE_BITS'(1);
                    s_d.toc_only = 1'b1;
                    s_d.any_full = 1'b0;
                end
            end
            SQD_GATE: begin
                s_d.gate_cnt = s_q.gate_cnt + 1'b1;
                if (rx_bit_in.valid) begin
                    s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                    if (s_d.fill == CNT_BITS'(WIN_BITS)) begin
                        s_d.any_full = 1'b1;
                        if (!sqd_is_turnoff(win_n)) begin
                            s_d.toc_only = 1'b0;
                        end
                    end
                end
                // The closing edge is outside the gate, so its bit is left out of the rate
                if (s_q.gate_cnt == 32'(GATE_CYCLES - 1)) begin
                    s_d.st      = SQD_ROTATE;
                    s_d.rate    = s_q.bit_cnt;
                    s_d.rot     = s_d.win;
                    s_d.rot_cnt = '0;
                    s_d.lcnt    = '0;
                end
            end
            SQD_ROTATE: begin
                // One alignment per cycle; only a full window can hold a code word
                if (cand && !dup && s_q.fill == CNT_BITS'(WIN_BITS)) begin
                    for (int i = 0; i < WIN_BITS; i++) begin
                        if (i == pos) begin
                            s_d.list[i] = code;
                        end else if (i > pos) begin
                            s_d.list[i] = s_q.list[i - 1];
                        end
                    end
                    s_d.lcnt = s_q.lcnt + 1'b1;
                end
                s_d.rot     = {s_q.rot[WIN_BITS-2:0], s_q.rot[WIN_BITS-1]};
                s_d.rot_cnt = s_q.rot_cnt + 1'b1;
                if (s_q.rot_cnt == CNT_BITS'(WIN_BITS - 1)) begin
                    s_d.st        = SQD_EMIT;
                    s_d.emit_idx  = '0;
                    s_d.head_done = 1'b0;
                end
            end
            SQD_EMIT: begin
                s_d.prim_ok  = p_ok;
                s_d.prim_idx = p_idx;
                if (!s_q.head_done) begin
                    push_valid = 1'b1;
                    if (s_q.toc_only && s_q.any_full) begin
                        push_entry.kind = SQD_ENT_TOC;
                    end else if (p_ok) begin
                        push_entry = '{kind: SQD_ENT_CODE, code: s_q.list[p_idx]};
                    end else begin
                        push_entry.kind = SQD_ENT_NPC;
                    end
                    if (fifo_ready) begin
                        s_d.head_done = 1'b1;
                        if (s_q.toc_only && s_q.any_full) begin
                            s_d.emit_idx = s_q.lcnt;
                        end
                    end
                end else if (s_q.emit_idx == s_q.lcnt) begin
                    // Turn-off-only period blanks the raw window
                    s_d.raw.valid = !(s_q.toc_only && s_q.any_full);
                    s_d.raw.bits  = s_q.rot;
                    s_d.done      = 1'b1;
                    s_d.busy      = 1'b0;
                    s_d.st        = continuous_in ? SQD_ARMED : SQD_IDLE;
                    s_d.armed     = continuous_in;
                end else if (s_q.prim_ok && s_q.emit_idx == s_q.prim_idx) begin
                    s_d.emit_idx = s_q.emit_idx + 1'b1;
                end else begin
                    push_valid = 1'b1;
                    push_entry = '{kind: SQD_ENT_CODE, code: s_q.list[s_q.emit_idx]};
                    if (fifo_ready) begin
                        s_d.emit_idx = s_q.emit_idx + 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = SQD_IDLE;
            end
        endcase

        // Stop aborts any measurement; entries already queued still drain
        if (stop_in) begin
            s_d.st    = SQD_IDLE;
            s_d.armed = 1'b0;
            s_d.busy  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result queue; a slow reader stalls the emit phase, not the bit window
    sqd_fifo #(
        .WIDTH ($bits(sqd_entry_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (push_valid),
        .in_data_in    (push_entry),
        .in_ready_out  (fifo_ready),
        .out_valid_out (entry_valid_out),
        .out_data_out  (entry_out),
        .out_ready_in  (entry_ready_in)
    );

    // Outputs straight from state flops
    assign raw_out      = s_q.raw;
    assign rate_bps_out = s_q.rate;
    assign armed_out    = s_q.armed;
    assign busy_out     = s_q.busy;
    assign done_out     = s_q.done;

endmodule

// ==== sim/sqd_tx_model.sv ====
module sqd_tx_model #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic         ref_clk_in,
    input  wire logic         en_in,
    input  wire logic         inv_in,
    input  wire logic [22:0]  word_in,
    output sqd_pkg::sqd_bit_s bit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sqd_pkg::*;
    int ph  = 0;
    int idx = 22;

    ////////////////////////////////////////////////////////////////////////////
    // Repeats the word MSB first at the configured rate; the level toggles between bits
    always @(negedge ref_clk_in) begin
        ph = en_in ? (ph + 1) % BIT_CYCLES : 0;
        bit_out.valid <= en_in && ph == 0;
        bit_out.level <= (en_in && ph == 0) ? word_in[idx] ^ inv_in : ~bit_out.level;
        if (en_in && ph == 0) idx = (idx == 0) ? 22 : idx - 1;
    end
endmodule

// ==== sim/sqd_decoder_asserts.sv ====
module sqd_decoder_asserts #(
    parameter int GATE_CYCLES = sqd_pkg::GATE_CYCLES_DEF
) (
    input wire logic                     ref_clk_in,
    input wire logic                     srst_in,
    input wire sqd_pkg::sqd_bit_s        rx_bit_in,
    input wire logic                     arm_in,
    input wire logic                     continuous_in,
    input wire logic                     stop_in,
    input wire sqd_pkg::sqd_raw_s        raw_out,
    input wire logic [15:0]              rate_bps_out,
    input wire sqd_pkg::sqd_entry_s      entry_out,
    input wire logic                     entry_valid_out,
    input wire logic                     entry_ready_in,
    input wire logic                     armed_out,
    input wire logic                     busy_out,
    input wire logic                     done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sqd_pkg::*;
    logic [31:0] busy_len_q;

    ////////////////////////////////////////////////////////////////////////////
    // Length of the busy stretch; a result cannot come before gate plus rotation
    always_ff @(posedge ref_clk_in) begin
        busy_len_q <= (srst_in || !busy_out) ? 32'h0 : busy_len_q + 32'h1;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_idle_req;
        !armed_out && !busy_out && (arm_in || continuous_in) && !stop_in;
    endsequence
    sequence s_trigger;
        armed_out && rx_bit_in.valid && !stop_in;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_arm_from_idle: assert property (s_idle_req |=> armed_out) else $error("arm not taken");
    a_trigger_starts: assert property (s_trigger |=> busy_out && !armed_out) else $error("no gate");
    a_one_state: assert property (!(armed_out && busy_out)) else $error("armed and busy");
    a_stop_clears: assert property (stop_in |=> !armed_out && !busy_out) else $error("stop ignored");
    a_result_len: assert property (done_out |-> busy_len_q >= GATE_CYCLES + 23) else $error("short");
    a_done_gap: assert property (done_out |=> !done_out [*8]) else $error("done too long");
    a_raw_at_done: assert property ($changed(raw_out) |-> done_out) else $error("raw moved");
    a_rate_at_gate: assert property ($changed(rate_bps_out) |-> busy_out) else $error("rate moved");
    a_rearm_cont: assert property (done_out && $past(continuous_in) && !$past(stop_in) |-> armed_out)
        else $error("no rearm");
    a_entry_hold: assert property (entry_valid_out && !entry_ready_in |=> entry_valid_out && $stable(entry_out))
        else $error("entry lost");
endmodule

bind sqd_decoder sqd_decoder_asserts #(.GATE_CYCLES(GATE_CYCLES)) i_asserts (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .rx_bit_in(rx_bit_in), .arm_in(arm_in),
    .continuous_in(continuous_in), .stop_in(stop_in), .raw_out(raw_out), .rate_bps_out(rate_bps_out),
    .entry_out(entry_out), .entry_valid_out(entry_valid_out), .entry_ready_in(entry_ready_in),
    .armed_out(armed_out), .busy_out(busy_out), .done_out(done_out));

// ==== sim/squelch_code_stream_decoder_tb.sv ====
module squelch_code_stream_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sqd_pkg::*;
    localparam int GATE = 200;
    localparam int BITC = 8;
    logic        ref_clk_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic        pol = 1'b0, arm = 1'b0, cont = 1'b0, stop = 1'b0, ready = 1'b0, tx_en = 1'b0;
    logic [22:0] tx_word = '0;
    logic [22:0] w;
    sqd_bit_s    rx_bit;
    sqd_raw_s    raw;
    sqd_entry_s  entry;
    logic [15:0] rate;
    logic        ent_v, armed, busy, done;
    logic [1:0]  got_k[$];
    logic [8:0]  got_c[$];
    int          ek[$], ec[$];
    int          fail_count = 0, comparisons = 0, cycles = 0;
    integer      seed = 32'he069;

    ////////////////////////////////////////////////////////////////////////////
    sqd_tx_model #(.BIT_CYCLES(BITC)) i_tx (.ref_clk_in(ref_clk_in), .en_in(tx_en), .inv_in(pol),
        .word_in(tx_word), .bit_out(rx_bit));
    sqd_decoder #(.GATE_CYCLES(GATE)) i_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .rx_bit_in(rx_bit),
        .polarity_invert_in(pol), .arm_in(arm), .continuous_in(cont), .stop_in(stop), .raw_out(raw),
        .rate_bps_out(rate), .entry_out(entry), .entry_valid_out(ent_v), .entry_ready_in(ready),
        .armed_out(armed), .busy_out(busy), .done_out(done));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, run limit, and a consumer that stalls at random so the queue backs up
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles > 12000) begin
            fail_count++;
            $display("mismatch %0t run did not finish", $time);
            give_verdict();
        end
    end
    always @(negedge ref_clk_in) ready <= ($random(seed) % 4) != 0;
    always @(posedge ref_clk_in) begin
        if (ent_v === 1'b1 && ready) begin
            got_k.push_back(entry.kind);
            got_c.push_back(entry.code);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference model: remainder, rotation test and expected entry list
    function automatic logic [10:0] rem23(input logic [22:0] v);
        for (int i = 22; i >= 11; i--) if (v[i]) v[i -: 12] ^= GEN_POLY;
        return v[10:0];
    endfunction
    function automatic bit is_rot(input logic [22:0] a, input logic [22:0] b);
        bit hit = 1'b0;
        for (int i = 0; i < 23; i++) begin
            hit |= (a === b);
            b = {b[21:0], b[22]};
        end
        return hit;
    endfunction
    task automatic expect_of(input logic [22:0] v);
        logic [511:0] f = '0;
        int           head = -1;
        if (is_rot(v, SQUELCH_TURNOFF_PATTERN)) begin
            ek.push_back(SQD_ENT_TOC);
            ec.push_back(0);
            return;
        end
        for (int r = 0; r < 23; r++) begin
            if (rem23(v) == 11'h0 && v[22:20] == CW_MARKER) f[v[19:11]] = 1'b1;
            v = {v[21:0], v[22]};
        end
        for (int c = 511; c >= 0; c--) if (f[c] && PRIMARY_MASK[c]) head = c;
        ek.push_back(head < 0 ? SQD_ENT_NPC : SQD_ENT_CODE);
        ec.push_back(head);
        for (int c = 0; c < 512; c++) begin
            if (f[c] && c != head) begin
                ek.push_back(SQD_ENT_CODE);
                ec.push_back(c);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Comparisons and the closing report
    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t value %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_entry(input int k, input int c);
        logic [1:0] gk;
        logic [8:0] gc;
        gk = got_k.pop_front();
        gc = got_c.pop_front();
        comparisons++;
        if (gk !== 2'(k) || (k == SQD_ENT_CODE && gc !== 9'(c))) begin
            fail_count++;
            $display("mismatch %0t entry %0d/%0o expected %0d/%0o", $time, gk, gc, k, c);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Wait for one result and compare it whole
    task automatic collect(input logic [22:0] v);
        int n = 0;
        bit squelch_turnoff_pattern;
        squelch_turnoff_pattern = is_rot(v, SQUELCH_TURNOFF_PATTERN);
        while (done !== 1'b1 && n < 2000) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        chk_val(done, 1);
        chk_val(raw.valid, !squelch_turnoff_pattern);
        if (!squelch_turnoff_pattern) chk_val(is_rot(raw.bits, v), 1);
        chk_val(rate, GATE / BITC);
        expect_of(v);
        repeat (60) @(posedge ref_clk_in);
        chk_val(got_k.size(), ek.size());
        while (ek.size() > 0 && got_k.size() > 0) chk_entry(ek.pop_front(), ec.pop_front());
        ek.delete();
        ec.delete();
        got_k.delete();
        got_c.delete();
    endtask
    // Load a stream, let the window fill, arm once
    task automatic measure(input logic [22:0] v, input logic iv);
        @(negedge ref_clk_in);
        tx_word = v;
        pol = iv;
        tx_en = 1'b1;
        repeat (24 * BITC) @(negedge ref_clk_in);
        arm = 1'b1;
        @(negedge ref_clk_in);
        arm = 1'b0;
        collect(v);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge ref_clk_in);
        srst_in = 1'b0;
        for (int i = 0; i < 6; i++) begin
            w = {CW_MARKER, 9'($random(seed)), 11'h0};
            w = w | rem23(w);
            measure(w, i[0]);
        end
        measure(23'($random(seed)), 1'b0);
        measure(SQUELCH_TURNOFF_PATTERN, 1'b1);
        measure(w, 1'b0);
        // Continuous mode runs two results back to back, then stop aborts
        @(negedge ref_clk_in);
        cont = 1'b1;
        collect(w);
        collect(w);
        @(negedge ref_clk_in);
        stop = 1'b1;
        cont = 1'b0;
        @(negedge ref_clk_in);
        stop = 1'b0;
        chk_val({armed, busy}, 0);
        // Reset in mid-run clears every output
        cont = 1'b1;
        repeat (30) @(negedge ref_clk_in);
        srst_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        chk_val({armed, busy, done, ent_v, raw, rate}, 0);
        // Release again and measure from an empty window
        cont = 1'b0;
        srst_in = 1'b0;
        measure(w, 1'b0);
        give_verdict();
    end
endmodule
